//--- src/tpg_core.sv
// Test pattern generator for the four down-converter output streams.
// Assumes live samples arrive on sys_clk and software uses the byte port.
// Summary of operation
// - Upper nibble of second converter select register picks its Q stream pattern.
// - Lower nibble of second converter select register picks its I stream pattern.
// - Code 0000 passes live data, 0001 drives zeros, 0010 drives ones.
// - Code 0011 alternates 1010 and 0101 words every sample.
// - Code 0100 drives a ramp from 0 rising by one each cycle to 65535.
// - Code 0110 drives the first user word continuously.
// - Code 0111 alternates first and second user words each sample.
// - Code 1000 drives the all ones deskew word.
// - Shared mode bit 0 makes all streams follow the common select field.
// - Shared mode bit 1 makes each stream follow its own select field.
// - Restart bit high with restart allowed holds generators at their start.
// - Restart bit is ignored unless the allow bit is one.
// - Two sixteen-bit user words written as four byte registers, reset zero.
// - Common select field uses the same codes as per-stream fields.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module tpg_core
  import tpg_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [7:0]        reg_rdata,
  // Sample streams
  input  wire tpg_pkg::tpg_streams_s live_in,
  output var  tpg_pkg::tpg_streams_s stream_out
);
  import tpg_pkg::*;

  // Register state
  logic [7:0]        ua_lo_q;
  logic [7:0]        ua_hi_q;
  logic [7:0]        ub_lo_q;
  logic [7:0]        ub_hi_q;
  logic [3:0]        common_q;
  logic [7:0]        ddc2_q;
  logic [7:0]        ddc1_q;
  logic              mode_q;
  logic              allow_q;
  logic              pulse_q;
  logic [7:0]        rdata_q;
  // Generator state
  logic [15:0]       ramp_q;
  logic [15:0]       ramp_d;
  logic              phase_q;
  logic              phase_d;
  tpg_streams_s      out_q;
  tpg_streams_s      out_d;

  // Write decode
  wire we_ua_lo   = reg_wr && (reg_addr == TPG_ADDR_UA_LO);
  wire we_ua_hi   = reg_wr && (reg_addr == TPG_ADDR_UA_HI);
  wire we_ub_lo   = reg_wr && (reg_addr == TPG_ADDR_UB_LO);
  wire we_ub_hi   = reg_wr && (reg_addr == TPG_ADDR_UB_HI);
  wire we_common  = reg_wr && (reg_addr == TPG_ADDR_COMMON);
  wire we_ddc2    = reg_wr && (reg_addr == TPG_ADDR_DDC2);
  wire we_ddc1    = reg_wr && (reg_addr == TPG_ADDR_DDC1);
  wire we_mode    = reg_wr && (reg_addr == TPG_ADDR_MODE);
  wire we_restart = reg_wr && (reg_addr == TPG_ADDR_RESTART);

  wire tpg_word_t user_a = {ua_hi_q, ua_lo_q};
  wire tpg_word_t user_b = {ub_hi_q, ub_lo_q};

  // Read mux; reserved bits and unmapped addresses give zero
  wire logic [7:0] rd_mux =
    (reg_addr == TPG_ADDR_UA_LO)   ? ua_lo_q :
    (reg_addr == TPG_ADDR_UA_HI)   ? ua_hi_q :
    (reg_addr == TPG_ADDR_UB_LO)   ? ub_lo_q :
    (reg_addr == TPG_ADDR_UB_HI)   ? ub_hi_q :
    (reg_addr == TPG_ADDR_COMMON)  ? {4'h0, common_q} :
    (reg_addr == TPG_ADDR_DDC2)    ? ddc2_q :
    (reg_addr == TPG_ADDR_DDC1)    ? ddc1_q :
    (reg_addr == TPG_ADDR_MODE)    ? {7'h00, mode_q} :
    (reg_addr == TPG_ADDR_RESTART) ? {6'h00, pulse_q, allow_q} :
                                     TPG_RD_ZERO;
  wire logic [7:0] rdata_d = reg_rd ? rd_mux : TPG_RD_ZERO;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      ua_lo_q <= TPG_RST_BYTE;
      ua_hi_q <= TPG_RST_BYTE;
      ub_lo_q <= TPG_RST_BYTE;
      ub_hi_q <= TPG_RST_BYTE;
    end
    else
    begin
      if (we_ua_lo) ua_lo_q <= reg_wdata;
      if (we_ua_hi) ua_hi_q <= reg_wdata;
      if (we_ub_lo) ub_lo_q <= reg_wdata;
      if (we_ub_hi) ub_hi_q <= reg_wdata;
    end
  end

  // Select, mode and restart control
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      common_q <= TPG_RST_BYTE[3:0];
      ddc2_q   <= TPG_RST_BYTE;
      ddc1_q   <= TPG_RST_BYTE;
      mode_q   <= 1'b0;
      allow_q  <= 1'b0;
      pulse_q  <= 1'b0;
      rdata_q  <= TPG_RST_BYTE;
    end
    else
    begin
      if (we_common) common_q <= reg_wdata[TPG_SEL_W-1:0];
      if (we_ddc2)   ddc2_q   <= reg_wdata;
      if (we_ddc1)   ddc1_q   <= reg_wdata;
      if (we_mode)   mode_q   <= reg_wdata[TPG_MODE_BIT];
      if (we_restart)
      begin
        allow_q <= reg_wdata[TPG_ALLOW_BIT];
        pulse_q <= reg_wdata[TPG_PULSE_BIT];
      end
      rdata_q <= rdata_d;
    end
  end

  wire gen_clr = pulse_q && allow_q;

  assign ramp_d  = gen_clr ? TPG_W_ZERO : tpg_word_t'(ramp_q + TPG_RAMP_STEP);
  assign phase_d = gen_clr ? 1'b0 : ~phase_q;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      ramp_q  <= TPG_W_ZERO;
      phase_q <= 1'b0;
      out_q   <= '0;
    end
    else
    begin
      ramp_q  <= ramp_d;
      phase_q <= phase_d;
      out_q   <= out_d;
    end
  end

  // Pattern word for one stream
  function automatic tpg_word_t tpg_pick(input logic [3:0] code,
                                         input tpg_word_t  live,
                                         input tpg_word_t  ramp,
                                         input tpg_word_t  ua,
                                         input tpg_word_t  ub,
                                         input logic       ph);
    case (code)
      TPG_PAT_ZERO:   tpg_pick = TPG_W_ZERO;
      TPG_PAT_ONES:   tpg_pick = TPG_W_ONES;
      TPG_PAT_TOGGLE: tpg_pick = ph ? TPG_W_TOG_B : TPG_W_TOG_A;
      TPG_PAT_RAMP:   tpg_pick = ramp;
      TPG_PAT_SINGLE: tpg_pick = ua;
      TPG_PAT_DOUBLE: tpg_pick = ph ? ub : ua;
      TPG_PAT_DESKEW: tpg_pick = TPG_W_DESKEW;
      default:        tpg_pick = live;
    endcase
  endfunction

  // Per-stream select fields, index 0 is first converter I
  wire logic [TPG_NS-1:0][3:0] own_sel = {
    // second converter Q and I nibbles
    ddc2_q[TPG_Q_LSB +: TPG_SEL_W], ddc2_q[TPG_I_LSB +: TPG_SEL_W],
    ddc1_q[TPG_Q_LSB +: TPG_SEL_W], ddc1_q[TPG_I_LSB +: TPG_SEL_W]};
  wire logic [TPG_NS-1:0][TPG_DW-1:0] live_v = live_in;
  logic [TPG_NS-1:0][3:0]        eff_sel;
  logic [TPG_NS-1:0][TPG_DW-1:0] pat_v;

  genvar gi;
  generate
    for (gi = 0; gi < TPG_NS; gi++)
    begin : g_stream
      assign eff_sel[gi] = mode_q ? own_sel[gi] : common_q;
      assign pat_v[gi]   = tpg_pick(eff_sel[gi], live_v[gi], ramp_q,
                                    user_a, user_b, phase_q);
    end
  endgenerate

  assign out_d      = pat_v;
  assign stream_out = out_q;
  assign reg_rdata  = rdata_q;

  // Checks start one cycle after reset so $past never sees reset values
  logic              armed_q;

  always_ff @(posedge sys_clk)
  begin
    armed_q <= nrst;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst || !armed_q);

  property p_q_sel;
    mode_q && ddc2_q[TPG_Q_LSB +: TPG_SEL_W] == TPG_PAT_ONES |=> stream_out.d2q == TPG_W_ONES;
  endproperty
  a_q_sel: assert property (p_q_sel) else $error("Q select ones wrong");

  property p_i_sel;
    mode_q && ddc2_q[TPG_I_LSB +: TPG_SEL_W] == TPG_PAT_ZERO |=> stream_out.d2i == TPG_W_ZERO;
  endproperty
  a_i_sel: assert property (p_i_sel) else $error("I select zeros wrong");

  property p_live;
    eff_sel[2] == TPG_PAT_LIVE |=> stream_out.d2i == $past(live_in.d2i);
  endproperty
  a_live: assert property (p_live) else $error("live pass wrong");

  property p_toggle;
    (eff_sel[3] == TPG_PAT_TOGGLE && !gen_clr) [*2] |=>
      stream_out.d2q == ~$past(stream_out.d2q) &&
      (stream_out.d2q == TPG_W_TOG_A || stream_out.d2q == TPG_W_TOG_B);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle wrong");

  property p_ramp;
    (eff_sel[2] == TPG_PAT_RAMP && !gen_clr) [*2] |=>
      stream_out.d2i == $past(stream_out.d2i) + TPG_RAMP_STEP;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp step wrong");

  property p_single;
    eff_sel[3] == TPG_PAT_SINGLE |=> stream_out.d2q == $past(user_a);
  endproperty
  a_single: assert property (p_single) else $error("single word wrong");

  property p_double;
    (eff_sel[0] == TPG_PAT_DOUBLE && !gen_clr && $stable(user_a) && $stable(user_b)) [*2] |=>
      stream_out.d1i == (($past(stream_out.d1i) == $past(user_a)) ?
                         $past(user_b) : $past(user_a));
  endproperty
  a_double: assert property (p_double) else $error("double word wrong");

  property p_deskew;
    eff_sel[0] == TPG_PAT_DESKEW |=> stream_out.d1i == TPG_W_DESKEW;
  endproperty
  a_deskew: assert property (p_deskew) else $error("deskew wrong");

  property p_common;
    !mode_q && common_q == TPG_PAT_ZERO |=> stream_out == '0;
  endproperty
  a_common: assert property (p_common) else $error("common select wrong");

  property p_own;
    mode_q && ddc1_q[TPG_Q_LSB +: TPG_SEL_W] == TPG_PAT_ONES && common_q == TPG_PAT_ZERO
      |=> stream_out.d1q == TPG_W_ONES;
  endproperty
  a_own: assert property (p_own) else $error("individual select wrong");

  property p_restart;
    gen_clr |=> ramp_q == TPG_W_ZERO && !phase_q;
  endproperty
  a_restart: assert property (p_restart) else $error("restart failed");

  property p_gate;
    !allow_q |=> ramp_q == $past(ramp_q) + TPG_RAMP_STEP;
  endproperty
  a_gate: assert property (p_gate) else $error("restart not gated");

  property p_user;
    we_ub_hi |=> user_b[15:8] == $past(reg_wdata);
  endproperty
  a_user: assert property (p_user) else $error("user word write wrong");

  property p_unlisted;
    eff_sel[1] == 4'b0101 |=> stream_out.d1q == $past(live_in.d1q);
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted code wrong");

  property p_rsvd;
    reg_rd && reg_addr == TPG_ADDR_MODE |=> reg_rdata[7:1] == 7'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

  property p_pad_ctl;
    reg_rd && reg_addr == TPG_ADDR_RESTART |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_pad_ctl: assert property (p_pad_ctl) else $error("restart pad bits set");

  property p_pad_sel;
    reg_rd && reg_addr == TPG_ADDR_COMMON |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_pad_sel: assert property (p_pad_sel) else $error("select pad bits set");

  property p_unmapped;
    reg_rd && (reg_addr < TPG_ADDR_UA_LO || reg_addr > TPG_ADDR_DDC1) |=>
      reg_rdata == TPG_RD_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_user_lo;
    we_ua_lo |=> user_a[7:0] == $past(reg_wdata);
  endproperty
  a_user_lo: assert property (p_user_lo) else $error("user word low byte wrong");

  property p_all_ones;
    !mode_q && common_q == TPG_PAT_ONES |=> stream_out == {TPG_NS{TPG_W_ONES}};
  endproperty
  a_all_ones: assert property (p_all_ones) else $error("common ones wrong");

  property p_all_live;
    !mode_q && common_q == TPG_PAT_LIVE |=> stream_out == $past(live_in);
  endproperty
  a_all_live: assert property (p_all_live) else $error("common live wrong");

  property p_ramp_run;
    gen_clr ##1 !gen_clr |=> ramp_q == TPG_RAMP_STEP;
  endproperty
  a_ramp_run: assert property (p_ramp_run) else $error("ramp start wrong");

  property p_hold_tog;
    gen_clr ##1 eff_sel[3] == TPG_PAT_TOGGLE |=> stream_out.d2q == TPG_W_TOG_A;
  endproperty
  a_hold_tog: assert property (p_hold_tog) else $error("held toggle wrong");

  c_ramp:    cover property (eff_sel[2] == TPG_PAT_RAMP [*3]);
  c_double:  cover property (eff_sel[0] == TPG_PAT_DOUBLE ##1 eff_sel[0] == TPG_PAT_DOUBLE);
  c_hold:    cover property (gen_clr ##1 eff_sel[3] == TPG_PAT_TOGGLE);
  c_restart: cover property (gen_clr ##1 !gen_clr);
  c_wrap:    cover property (ramp_q == TPG_W_ONES ##1 ramp_q == TPG_W_ZERO);

endmodule

`default_nettype wire

//--- common/tpg_pkg.sv
// Package for the down-converter output test pattern generator.
// Assumes one sample clock; all stream words are sixteen bits wide.
package tpg_pkg;

  // Register byte addresses
  localparam logic [7:0] TPG_ADDR_UA_LO   = 8'h33;
  localparam logic [7:0] TPG_ADDR_UA_HI   = 8'h34;
  localparam logic [7:0] TPG_ADDR_UB_LO   = 8'h35;
  localparam logic [7:0] TPG_ADDR_UB_HI   = 8'h36;
  localparam logic [7:0] TPG_ADDR_COMMON  = 8'h37;
  localparam logic [7:0] TPG_ADDR_DDC2    = 8'h38;
  localparam logic [7:0] TPG_ADDR_MODE    = 8'h39;
  localparam logic [7:0] TPG_ADDR_RESTART = 8'h3a;
  localparam logic [7:0] TPG_ADDR_DDC1    = 8'h3b;

  // Field layout and reset values
  localparam int         TPG_SEL_W       = 4;
  localparam int         TPG_I_LSB       = 0;
  localparam int         TPG_Q_LSB       = 4;
  localparam int         TPG_ALLOW_BIT   = 0;
  localparam int         TPG_PULSE_BIT   = 1;
  localparam int         TPG_MODE_BIT    = 0;
  localparam logic [7:0] TPG_RST_BYTE    = 8'h00;
  localparam logic [7:0] TPG_RD_ZERO     = 8'h00;

  // Stream layout
  localparam int         TPG_DW          = 16;
  localparam int         TPG_NS          = 4;
  localparam logic [15:0] TPG_W_ZERO     = 16'h0000;
  localparam logic [15:0] TPG_W_ONES     = 16'hffff;
  localparam logic [15:0] TPG_W_TOG_A    = 16'haaaa;
  localparam logic [15:0] TPG_W_TOG_B    = 16'h5555;
  localparam logic [15:0] TPG_W_DESKEW   = 16'hffff;
  localparam logic [15:0] TPG_RAMP_STEP  = 16'h0001;

  // Pattern codes
  typedef enum logic [3:0] {
    TPG_PAT_LIVE   = 4'b0000,
    TPG_PAT_ZERO   = 4'b0001,
    TPG_PAT_ONES   = 4'b0010,
    TPG_PAT_TOGGLE = 4'b0011,
    TPG_PAT_RAMP   = 4'b0100,
    TPG_PAT_SINGLE = 4'b0110,
    TPG_PAT_DOUBLE = 4'b0111,
    TPG_PAT_DESKEW = 4'b1000
  } tpg_code_e;

  typedef logic [15:0] tpg_word_t;

  // Four sample streams; first converter in the low half
  typedef struct packed {
    tpg_word_t d2q;
    tpg_word_t d2i;
    tpg_word_t d1q;
    tpg_word_t d1i;
  } tpg_streams_s;

endpackage

//--- test/tpg_sink.sv
// Far-side model: serial output logic that latches every sample word.
// Assumes it shares sys_clk and nrst with the generator.
`timescale 1ns/1ns
`default_nettype none

module tpg_sink
  import tpg_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  // Sample streams
  input  wire tpg_pkg::tpg_streams_s stream_in,
  output var  tpg_pkg::tpg_streams_s rx_q
);
  import tpg_pkg::*;

  always_ff @(posedge sys_clk)
  begin
    rx_q <= nrst ? stream_in : '0;
  end
endmodule

`default_nettype wire

//--- test/tb_tpg_core.sv
// Self-checking bench for the test pattern generator.
// Assumes generator and latching sink share one 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("MISMATCH %s exp=%h got=%h", nm, e, g); \
    end \
  end

module tb_tpg_core;
  import tpg_pkg::*;
  logic         sys_clk, nrst, reg_wr, reg_rd, rd_d;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata, ev8;
  logic [1:0]   sreq;
  logic [63:0]  ev64;
  tpg_streams_s live_in, stream_out, rx_q, prv, x, got, lv;
  tpg_word_t    ua, ub;
  logic [7:0]   rq[$];
  logic [63:0]  sq[$];
  int           miscompares, total_checks;

  tpg_core i_tpg_core (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .live_in(live_in), .stream_out(stream_out));
  tpg_sink i_tpg_sink (.sys_clk(sys_clk), .nrst(nrst), .stream_in(stream_out), .rx_q(rx_q));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rq.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  // Let settings reach the sink, then check n samples (kind 1 value, kind 2 step)
  task automatic run(input logic [1:0] k, input logic [63:0] e, input int n);
    repeat (4) @(posedge sys_clk);
    repeat (n) sq.push_back(e);
    sreq <= k;
    repeat (n) @(posedge sys_clk);
    sreq <= 2'd0;
  endtask

  function automatic tpg_streams_s pat(input logic [3:0] c, input tpg_streams_s l);
    case (c)
      4'h1: pat = {4{16'h0000}};
      4'h2, 4'h8: pat = {4{16'hffff}};
      4'h6: pat = {4{ua}};
      default: pat = l;
    endcase
  endfunction

  always @(posedge sys_clk)
    rd_d <= reg_rd;

  // Step kind: toggle/user lanes as xor of neighbours, ramp lane as difference
  always @(negedge sys_clk)
  begin
    prv <= rx_q;
    x = rx_q ^ prv;
    got = (sreq == 2'd2) ? {x.d2q, rx_q.d2i - prv.d2i, x.d1q, x.d1i} : rx_q;
    if (rd_d)
    begin
      ev8 = rq.pop_front();
      `CHK("reg_rdata", ev8, reg_rdata)
    end
    if (sreq != 2'd0)
    begin
      ev64 = sq.pop_front();
      `CHK("stream_out", ev64, got)
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    miscompares++;
    conclude();
  end

  initial
  begin
    void'($urandom(64950));
    {nrst, reg_wr, reg_rd, sreq} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    live_in = '0;
    ua = 16'($urandom);
    ub = 16'($urandom);
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int a = 8'h33; a <= 8'h3b; a++)
      rd(a[7:0], TPG_RST_BYTE);
    lv = {$urandom, $urandom};
    live_in <= lv;
    run(2'd1, lv, 4);
    $display("test reset done");
    wr(TPG_ADDR_UA_LO, ua[7:0]);
    wr(TPG_ADDR_UA_HI, ua[15:8]);
    wr(TPG_ADDR_UB_LO, ub[7:0]);
    wr(TPG_ADDR_UB_HI, ub[15:8]);
    wr(TPG_ADDR_COMMON, 8'hff);
    wr(TPG_ADDR_MODE, 8'hfe);
    wr(TPG_ADDR_RESTART, 8'hfe);
    wr(8'h40, 8'hff);
    rd(TPG_ADDR_UA_LO, ua[7:0]);
    rd(TPG_ADDR_UA_HI, ua[15:8]);
    rd(TPG_ADDR_UB_LO, ub[7:0]);
    rd(TPG_ADDR_UB_HI, ub[15:8]);
    rd(TPG_ADDR_COMMON, 8'h0f);
    rd(TPG_ADDR_MODE, 8'h00);
    rd(TPG_ADDR_RESTART, 8'h02);
    rd(8'h40, TPG_RD_ZERO);
    $display("test registers done");
    for (int c = 0; c < 16; c++)
      if (c != 3 && c != 4 && c != 7)
      begin
        lv = {$urandom, $urandom};
        live_in <= lv;
        wr(TPG_ADDR_COMMON, 8'(c));
        run(2'd1, pat(4'(c), lv), 2);
      end
    $display("test common done");
    wr(TPG_ADDR_MODE, 8'h01);
    wr(TPG_ADDR_DDC2, 8'h61);
    wr(TPG_ADDR_DDC1, 8'h20);
    wr(TPG_ADDR_COMMON, 8'h01);
    lv = {$urandom, $urandom};
    live_in <= lv;
    run(2'd1, {ua, 16'h0000, 16'hffff, lv.d1i}, 3);
    $display("test individual done");
    wr(TPG_ADDR_DDC2, 8'h34);
    wr(TPG_ADDR_DDC1, 8'h67);
    run(2'd2, {16'hffff, 16'h0001, 16'h0000, ua ^ ub}, 6);
    // Allow first, then hold the generators at their start
    wr(TPG_ADDR_RESTART, 8'h01);
    wr(TPG_ADDR_RESTART, 8'h03);
    run(2'd1, {16'haaaa, 16'h0000, ua, ua}, 4);
    wr(TPG_ADDR_RESTART, 8'h01);
    run(2'd2, {16'hffff, 16'h0001, 16'h0000, ua ^ ub}, 8);
    $display("test restart done");
    conclude();
  end
endmodule

`default_nettype wire
